/* verilog/cfgsp_consts.svh */
// constants of the configurable-pin serial port: frame, timing, commands
`ifndef CFGSP_CONSTS_SVH
`define CFGSP_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// frame and buffer shape
`define CFGSP_FRAME_BITS     5'h10
`define CFGSP_WORD_W         16
`define CFGSP_FIFO_DEPTH     8
`define CFGSP_FIFO_AW        3
`define CFGSP_PINS           8

////////////////////////////////////////////////////////////////////////////////
// timing: main clock, serial clock made by the host, conversion time
`define CFGSP_MCLK_NS        50
`define CFGSP_SCLK_WR_MAX_MHZ 50
`define CFGSP_SCLK_RD_MAX_MHZ 20
`define CFGSP_SCLK_NS        400
`define CFGSP_SCLK_HALF      ((`CFGSP_SCLK_NS / `CFGSP_MCLK_NS) / 2)
`define CFGSP_CONV_NS        2500
`define CFGSP_CONV_CYC       ((`CFGSP_CONV_NS + `CFGSP_MCLK_NS - 1) / `CFGSP_MCLK_NS)

////////////////////////////////////////////////////////////////////////////////
// command word fields and codes
`define CFGSP_CMD_MSB        15
`define CFGSP_CMD_LSB        12
`define CFGSP_PIN_MSB        10
`define CFGSP_PIN_LSB        8
`define CFGSP_CMD_MODE       4'h1
`define CFGSP_CMD_GPIO       4'h2
`define CFGSP_CMD_READ       4'h3
`define CFGSP_CMD_CONV       4'h4
`define CFGSP_CMD_BUSY       4'h5
`define CFGSP_RD_GPIO_IN     2'h0
`define CFGSP_RD_GPIO_OUT    2'h1
`define CFGSP_RD_TEMP        2'h2

////////////////////////////////////////////////////////////////////////////////
// reset values
`define CFGSP_GPO_RST        8'h00
`define CFGSP_BUSY_EN_RST    1'h0
`define CFGSP_SYNC_RST       3'h2

`endif

/* verilog/cfgsp_pkg.sv */
// types shared by both ends of the configurable-pin serial port
package cfgsp_pkg;

    // function of one configurable pin
    typedef enum logic [2:0] {
        CFGSP_PIN_OFF  = 3'b000,
        CFGSP_PIN_DAC  = 3'b001,
        CFGSP_PIN_ADC  = 3'b010,
        CFGSP_PIN_DIN  = 3'b011,
        CFGSP_PIN_DOUT = 3'b100
    } cfgsp_pin_mode_t;

    // host frame sequencer
    typedef enum logic [2:0] {
        CFGSP_H_IDLE  = 3'b000,
        CFGSP_H_SETUP = 3'b001,
        CFGSP_H_HIGH  = 3'b010,
        CFGSP_H_LOW   = 3'b011,
        CFGSP_H_GAP   = 3'b100
    } cfgsp_host_st_t;

endpackage

/* verilog/cfgsp_if.sv */
// serial link between the host and the configurable-pin device
`timescale 1ns/1ns
interface cfgsp_if;
    logic sclk;
    logic sync_n;
    logic serial_data_in;
    logic serial_data_out;
    logic rst_n;

    modport dev (input sclk, input sync_n, input serial_data_in, input rst_n, output serial_data_out);
    modport host (output sclk, output sync_n, output serial_data_in, output rst_n, input serial_data_out);
endinterface

/* verilog/cfgsp_dev.sv */
// device end: serial target, pin configuration, conversion sequencer, reply fifo
`timescale 1ns/1ns
`include "cfgsp_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// reply buffer: flop storage, one extra pointer bit tells full from empty
module cfgsp_fifo #(
    parameter int W  = 16,
    parameter int D  = 8,
    parameter int AW = 3
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] mem_q [D];
    logic [AW:0]  wp_q;
    logic [AW:0]  rp_q;
    wire          push = in_valid & in_ready;
    wire          pop  = out_valid & out_ready;

    // occupancy flags straight from the pointers
    assign in_ready  = (wp_q[AW-1:0] != rp_q[AW-1:0]) | (wp_q[AW] == rp_q[AW]);
    assign out_valid = wp_q != rp_q;
    assign out_data  = mem_q[rp_q[AW-1:0]];

    // storage written only on accepted pushes
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module cfgsp_dev (
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    cfgsp_if.dev             LINK,
    input  wire logic [7:0]  CONFIG_PIN_IN,
    input  wire logic [11:0] ADC_SAMPLE,
    input  wire logic [11:0] TEMP_CODE,
    output logic      [7:0]  CONFIG_PIN_OUT,
    output logic      [7:0]  CONFIG_PIN_OE_N,
    output logic             BUSY
);
    localparam logic [5:0] CONV_N = 6'(`CFGSP_CONV_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // reset: either source clears at once, release is synchronised to MCLK
    wire        arst = SYS_RST | ~LINK.rst_n;
    logic [1:0] rsync_q;
    wire        rst  = ~rsync_q[1];

    // release follows two clean edges so no flop sees a runt release
    always_ff @(posedge MCLK or posedge arst) begin
        if (arst) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link inputs: two flops each, a third stage only for edge finding
    logic [2:0] lm_q;
    logic [2:0] ls_q;
    logic [1:0] lp_q;
    logic [7:0] pm_q;
    logic [7:0] ps_q;

    always_ff @(posedge MCLK or posedge rst) begin
        if (rst) begin
            lm_q <= `CFGSP_SYNC_RST;
            ls_q <= `CFGSP_SYNC_RST;
            lp_q <= 2'h1;
            pm_q <= 8'h00;
            ps_q <= 8'h00;
        end else begin
            lm_q <= {LINK.sclk, LINK.sync_n, LINK.serial_data_in};
            ls_q <= lm_q;
            lp_q <= ls_q[2:1];
            pm_q <= CONFIG_PIN_IN;
            ps_q <= pm_q;
        end
    end

    // edges of the sampled serial clock and frame select
    wire sclk_s    = ls_q[2];
    wire sync_s    = ls_q[1];
    wire sdi_s     = ls_q[0];
    wire sclk_fall = lp_q[1] & ~sclk_s;
    wire sclk_rise = ~lp_q[1] & sclk_s;
    wire sync_fall = lp_q[0] & ~sync_s;
    wire sync_rise = ~lp_q[0] & sync_s;

    ////////////////////////////////////////////////////////////////////////////
    // frame shifter
    logic [4:0]  cnt_q;
    logic [15:0] rx_q;
    logic [15:0] tx_q;
    logic        fell_q;
    logic        sdo_q;
    logic        fo_valid;
    logic [15:0] fo_data;
    wire  [15:0] tx_load = fo_valid ? fo_data : 16'h0000; // empty buffer sends zeros

    assign LINK.serial_data_out = sdo_q;

    // in on falls, out on the first rise after each fall
    always_ff @(posedge MCLK or posedge rst) begin
        if (rst) begin
            cnt_q  <= 5'h00;
            rx_q   <= 16'h0000;
            tx_q   <= 16'h0000;
            fell_q <= 1'b0;
            sdo_q  <= 1'b0;
        end else if (sync_fall) begin
            cnt_q  <= 5'h00;
            fell_q <= 1'b0;
            tx_q   <= tx_load;
            sdo_q  <= tx_load[15];
        end else if (!sync_s) begin
            if (sclk_fall && cnt_q != `CFGSP_FRAME_BITS) begin
                rx_q   <= {rx_q[14:0], sdi_s};
                cnt_q  <= cnt_q + 5'h01;
            end
            if (sclk_fall) begin
                fell_q <= 1'b1;
            end else if (sclk_rise && fell_q) begin
                tx_q   <= {tx_q[14:0], 1'b0};
                sdo_q  <= tx_q[14];
                fell_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command decode; only a complete frame acts on select rising
    wire       exec    = sync_rise & (cnt_q == `CFGSP_FRAME_BITS);
    wire [3:0] cmd     = rx_q[`CFGSP_CMD_MSB:`CFGSP_CMD_LSB];
    wire [2:0] pin_idx = rx_q[`CFGSP_PIN_MSB:`CFGSP_PIN_LSB];
    wire [2:0] ch      = rx_q[2:0];
    wire [1:0] rd_sel  = rx_q[1:0];
    wire       mode_ok = rx_q[2:0] <= 3'(cfgsp_pkg::CFGSP_PIN_DOUT);

    cfgsp_pkg::cfgsp_pin_mode_t mode_q [`CFGSP_PINS];
    logic [7:0]  gpo_q;
    logic        busy_en_q;
    logic [5:0]  conv_cnt_q;
    logic [2:0]  conv_ch_q;
    logic [11:0] res_q;
    logic        done_q;
    logic [7:0]  din_mask;
    logic        fi_ready;

    wire conv_busy  = conv_cnt_q != 6'h00;
    wire conv_start = exec & (cmd == `CFGSP_CMD_CONV) & ~conv_busy & ~done_q &
                      (mode_q[ch] == cfgsp_pkg::CFGSP_PIN_ADC);
    wire rd_req     = exec & (cmd == `CFGSP_CMD_READ);

    // readback value; input levels only show on digital-input pins
    wire [11:0] rd_val  = (rd_sel == `CFGSP_RD_GPIO_IN)  ? {4'h0, ps_q & din_mask} :
                          (rd_sel == `CFGSP_RD_GPIO_OUT) ? {4'h0, gpo_q} :
                          (rd_sel == `CFGSP_RD_TEMP)     ? TEMP_CODE : 12'h000;
    wire [15:0] rd_word = {2'h0, rd_sel, rd_val};
    wire [15:0] cv_word = {1'b1, conv_ch_q, res_q};

    // a pending result owns the push port; a read arriving then is dropped
    wire        fi_valid = done_q | rd_req;
    wire [15:0] fi_data  = done_q ? cv_word : rd_word;

    // configuration registers
    always_ff @(posedge MCLK or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `CFGSP_PINS; i++) begin
                mode_q[i] <= cfgsp_pkg::CFGSP_PIN_OFF;
            end
            gpo_q     <= `CFGSP_GPO_RST;
            busy_en_q <= `CFGSP_BUSY_EN_RST;
        end else if (exec) begin
            if (cmd == `CFGSP_CMD_MODE && mode_ok) begin
                mode_q[pin_idx] <= cfgsp_pkg::cfgsp_pin_mode_t'(rx_q[2:0]);
            end
            if (cmd == `CFGSP_CMD_GPIO) begin
                gpo_q <= rx_q[7:0];
            end
            if (cmd == `CFGSP_CMD_BUSY) begin
                busy_en_q <= rx_q[0];
            end
        end
    end

    // conversion timer; a result waits in done_q while the buffer is full
    always_ff @(posedge MCLK or posedge rst) begin
        if (rst) begin
            conv_cnt_q <= 6'h00;
            conv_ch_q  <= 3'h0;
            res_q      <= 12'h000;
            done_q     <= 1'b0;
        end else begin
            if (conv_start) begin
                conv_cnt_q <= CONV_N;
                conv_ch_q  <= ch;
            end else if (conv_busy) begin
                conv_cnt_q <= conv_cnt_q - 6'h01;
            end
            if (conv_cnt_q == 6'h01) begin
                res_q  <= ADC_SAMPLE;
                done_q <= 1'b1;
            end else if (done_q && fi_ready) begin
                done_q <= 1'b0;
            end
        end
    end

    cfgsp_fifo #(
        .W  (`CFGSP_WORD_W),
        .D  (`CFGSP_FIFO_DEPTH),
        .AW (`CFGSP_FIFO_AW)
    ) u_reply (
        .clk       (MCLK),
        .rst       (rst),
        .in_valid  (fi_valid),
        .in_ready  (fi_ready),
        .in_data   (fi_data),
        .out_valid (fo_valid),
        .out_ready (sync_fall),
        .out_data  (fo_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers; analog modes leave the digital driver off, except on pin 7 while busy output is on
    for (genvar i = 0; i < `CFGSP_PINS; i++) begin : g_pin
        wire busy_pin = (i == `CFGSP_PINS - 1) & busy_en_q;
        wire drive    = busy_pin | (mode_q[i] == cfgsp_pkg::CFGSP_PIN_DOUT);
        assign din_mask[i] = mode_q[i] == cfgsp_pkg::CFGSP_PIN_DIN;

        always_ff @(posedge MCLK or posedge rst) begin
            if (rst) begin
                CONFIG_PIN_OUT[i]  <= 1'b0;
                CONFIG_PIN_OE_N[i] <= 1'b1;
            end else begin
                CONFIG_PIN_OUT[i]  <= busy_pin ? conv_busy : (drive & gpo_q[i]);
                CONFIG_PIN_OE_N[i] <= ~drive;
            end
        end
    end

    // busy flag for the user side
    always_ff @(posedge MCLK or posedge rst) begin
        if (rst) begin
            BUSY <= 1'b0;
        end else begin
            BUSY <= conv_busy;
        end
    end
endmodule

/* verilog/cfgsp_host.sv */
// host end: makes the serial clock and runs one 16-bit frame per command
`timescale 1ns/1ns
`include "cfgsp_consts.svh"

module cfgsp_host (
    input  wire logic        MCLK,
    input  wire logic        SYS_RST,
    cfgsp_if.host            LINK,
    input  wire logic        CMD_VALID,
    input  wire logic [15:0] CMD_WORD,
    output logic             CMD_READY,
    output logic             RSP_VALID,
    output logic      [15:0] RSP_WORD
);
    // one serial period is two half phases of MCLK cycles
    localparam logic [3:0] HALF_M1 = 4'(`CFGSP_SCLK_HALF - 1);

    cfgsp_pkg::cfgsp_host_st_t st_q;
    logic [3:0]  div_q;
    logic [4:0]  bit_q;
    logic [15:0] tx_q;
    logic [15:0] rx_q;
    logic        sclk_q;
    logic        sync_n_q;
    logic        sdi_q;
    logic        rst_n_q;
    logic [1:0]  sdo_q;

    wire tick = div_q == HALF_M1;
    wire take = (st_q == cfgsp_pkg::CFGSP_H_IDLE) & CMD_READY & CMD_VALID;

    assign LINK.sclk           = sclk_q;
    assign LINK.sync_n         = sync_n_q;
    assign LINK.serial_data_in = sdi_q;
    assign LINK.rst_n          = rst_n_q;

    ////////////////////////////////////////////////////////////////////////////
    // reply pin synchroniser and device reset hold
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sdo_q   <= 2'h0;
            rst_n_q <= 1'b0;
        end else begin
            sdo_q   <= {sdo_q[0], LINK.serial_data_out};
            rst_n_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // half-phase divider, restarted on every phase change
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            div_q <= 4'h0;
        end else if (tick || st_q == cfgsp_pkg::CFGSP_H_IDLE) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame sequencer: data changes only at select fall and on rises, reply sampled late in low
    // phase so the device's two-flop input delay is covered
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_q      <= cfgsp_pkg::CFGSP_H_IDLE;
            bit_q     <= 5'h00;
            tx_q      <= 16'h0000;
            rx_q      <= 16'h0000;
            sclk_q    <= 1'b0;
            sync_n_q  <= 1'b1;
            sdi_q     <= 1'b0;
            CMD_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_WORD  <= 16'h0000;
        end else begin
            RSP_VALID <= 1'b0;
            case (st_q)
                cfgsp_pkg::CFGSP_H_IDLE: begin
                    CMD_READY <= ~take;
                    if (take) begin
                        tx_q     <= CMD_WORD;
                        sdi_q    <= CMD_WORD[15];
                        sync_n_q <= 1'b0;
                        bit_q    <= 5'h00;
                        st_q     <= cfgsp_pkg::CFGSP_H_SETUP;
                    end
                end
                cfgsp_pkg::CFGSP_H_SETUP: begin
                    if (tick) begin
                        sclk_q <= 1'b1;
                        st_q   <= cfgsp_pkg::CFGSP_H_HIGH;
                    end
                end
                cfgsp_pkg::CFGSP_H_HIGH: begin
                    if (tick) begin
                        sclk_q <= 1'b0;
                        bit_q  <= bit_q + 5'h01;
                        st_q   <= cfgsp_pkg::CFGSP_H_LOW;
                    end
                end
                cfgsp_pkg::CFGSP_H_LOW: begin
                    if (tick) begin
                        rx_q <= {rx_q[14:0], sdo_q[1]};
                        if (bit_q == `CFGSP_FRAME_BITS) begin
                            sync_n_q <= 1'b1;
                            st_q     <= cfgsp_pkg::CFGSP_H_GAP;
                        end else begin
                            sclk_q <= 1'b1;
                            sdi_q  <= tx_q[14];
                            tx_q   <= {tx_q[14:0], 1'b0};
                            st_q   <= cfgsp_pkg::CFGSP_H_HIGH;
                        end
                    end
                end
                cfgsp_pkg::CFGSP_H_GAP: begin
                    // select stays high a half phase, well over the read minimum
                    if (tick) begin
                        RSP_VALID <= 1'b1;
                        RSP_WORD  <= rx_q;
                        st_q      <= cfgsp_pkg::CFGSP_H_IDLE;
                    end
                end
                default: begin
                    st_q <= cfgsp_pkg::CFGSP_H_IDLE;
                end
            endcase
        end
    end
endmodule

/* tb/cfgsp_sva.sv */
// wire checker for the serial link between host and device
`timescale 1ns/1ns
module cfgsp_sva (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic rst_n
);
    logic [7:0] lo_q;
    logic [4:0] fall_q;
    logic       sclk_p_q;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);

    ////////////////////////////////////////////////////////////////////////////////
    // frame length and clock falls, cleared while select is high
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            lo_q     <= 8'h00;
            fall_q   <= 5'h00;
            sclk_p_q <= 1'b0;
        end else begin
            sclk_p_q <= sclk;
            lo_q     <= sync_n ? 8'h00 : lo_q + 8'h01;
            fall_q   <= sync_n ? 5'h00 : fall_q + {4'h0, sclk_p_q & ~sclk};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reset pin and reset state of the reply line
    property p_rst_hold;
        !$past(SYS_RST) |-> rst_n;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("device reset dropped in operation");
    property p_sdo_rst;
        $rose(rst_n) |-> !serial_data_out;
    endproperty
    a_sdo_rst: assert property (p_sdo_rst) else $error("reply line not cleared by reset");

    // framing: clock idles low, setup after select, 16 falls in 132 cycles
    property p_sync_setup;
        $fell(sync_n) |-> (!sclk)[*4] ##1 sclk;
    endproperty
    a_sync_setup: assert property (p_sync_setup) else $error("first clock rise misplaced");
    property p_idle_clk;
        sync_n |-> !sclk;
    endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("clock moves outside a frame");
    property p_frame_len;
        $rose(sync_n) |-> lo_q == 8'h84;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
    property p_frame_falls;
        $rose(sync_n) |-> fall_q == 5'h10;
    endproperty
    a_frame_falls: assert property (p_frame_falls) else $error("frame does not hold 16 falls");

    // clock phases stay well inside the rate limits
    property p_sclk_high;
        $rose(sclk) |-> sclk[*4] ##1 !sclk;
    endproperty
    a_sclk_high: assert property (p_sclk_high) else $error("clock high phase wrong");
    property p_sclk_low;
        $fell(sclk) && !sync_n |-> (!sclk)[*4];
    endproperty
    a_sclk_low: assert property (p_sclk_low) else $error("clock low phase too short");

    // data in is steady across the sampling fall
    property p_sdi_hold;
        $fell(sclk) |-> serial_data_in == $past(serial_data_in, 4);
    endproperty
    a_sdi_hold: assert property (p_sdi_hold) else $error("data in moved before the fall");

    // reply line moves only 3 samples after a clock rise or a select fall is seen
    property p_sdo_move;
        $changed(serial_data_out) |-> ($past(sclk, 3) && !$past(sclk, 4)) || (!$past(sync_n, 3) && $past(sync_n, 4));
    endproperty
    a_sdo_move: assert property (p_sdo_move) else $error("reply bit moved at a wrong time");
endmodule

/* tb/config_io_serial_port_tb.sv */
// bench: host and device joined, a second device bit-banged, reply order through the device
`timescale 1ns/1ns
module config_io_serial_port_tb;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cmd_valid = 1'b0;
    logic [15:0] cmd_word = 16'h0000;
    logic        cmd_ready;
    logic        rsp_valid;
    logic [15:0] rsp_word;
    logic [7:0]  pin_in = 8'h81;
    logic [11:0] adc = 12'h3c7;
    logic [11:0] temp = 12'ha5c;
    logic [7:0]  pout1, poe1, pout2, poe2;
    logic        busy1, busy2;
    int          n_fail = 0;
    int          compares = 0;

    cfgsp_if l1 ();
    cfgsp_if l2 ();

    // 20 MHz main clock
    always #25 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    cfgsp_host cfgsp_host_i (.MCLK(mclk), .SYS_RST(sys_rst), .LINK(l1), .CMD_VALID(cmd_valid),
        .CMD_WORD(cmd_word), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_WORD(rsp_word));
    cfgsp_dev cfgsp_dev_i (.MCLK(mclk), .SYS_RST(sys_rst), .LINK(l1), .CONFIG_PIN_IN(pin_in),
        .ADC_SAMPLE(adc), .TEMP_CODE(temp), .CONFIG_PIN_OUT(pout1), .CONFIG_PIN_OE_N(poe1), .BUSY(busy1));
    // second device: the bench plays host to make short frames
    cfgsp_dev cfgsp_dev_bb_i (.MCLK(mclk), .SYS_RST(sys_rst), .LINK(l2), .CONFIG_PIN_IN(pin_in),
        .ADC_SAMPLE(adc), .TEMP_CODE(temp), .CONFIG_PIN_OUT(pout2), .CONFIG_PIN_OE_N(poe2), .BUSY(busy2));
    cfgsp_sva cfgsp_sva_i (.MCLK(mclk), .SYS_RST(sys_rst), .sclk(l1.sclk), .sync_n(l1.sync_n),
        .serial_data_in(l1.serial_data_in), .serial_data_out(l1.serial_data_out), .rst_n(l1.rst_n));

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic results;
        if (n_fail == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // bounded wait: 0 host ready, 1 reply pulse, 2 conversion over
    task automatic wait_for(input int sel);
        int k;
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (!(sel == 0 ? cmd_ready === 1'b1 : sel == 1 ? rsp_valid === 1'b1 : busy1 === 1'b0) && k < 300);
        if (k >= 300) begin
            n_fail++;
            results();
        end
    endtask

    // one frame through the host; request held until the edge that takes it
    task automatic run(input logic [15:0] w, output logic [15:0] r);
        wait_for(0);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_word  <= w;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        wait_for(1);
        r = rsp_word;
    endtask

    // bit-banged frame of n falls; data line inverted once released
    task automatic bb(input logic [15:0] w, input int n);
        @(posedge mclk); // link pins move on rising edges only
        l2.sync_n <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = 15; i > 15 - n; i--) begin
            l2.serial_data_in <= w[i];
            l2.sclk           <= 1'b1;
            repeat (4) @(posedge mclk);
            l2.sclk <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        l2.sync_n         <= 1'b1;
        l2.serial_data_in <= ~l2.serial_data_in;
        repeat (8) @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // readbacks, pin modes and the one-frame reply delay
    task automatic t_regs;
        logic [15:0] r;
        run(16'h3002, r);
        chk(r, 16'h0000);
        run(16'h1304, r);
        chk(r, {4'h2, temp});
        run(16'h2008, r);
        chk(r, 16'h0000);
        settle(8);
        chk({8'h00, poe1}, 16'h00f7);
        chk({8'h00, pout1 & 8'h08}, 16'h0008);
        run(16'h1003, r);
        run(16'h3000, r);
        run(16'h3001, r);
        chk(r, 16'h0001);
        run(16'h1202, r);
        chk(r, 16'h1008);
    endtask

    // conversion with busy on pin seven, then a refused start
    task automatic t_conv;
        logic [15:0] r;
        run(16'h5001, r);
        run(16'h4002, r);
        settle(4);
        chk({13'h0000, busy1, poe1[7], pout1[7]}, 16'h0005);
        wait_for(2);
        settle(2);
        chk({15'h0000, pout1[7]}, 16'h0000);
        run(16'h3002, r);
        chk(r, {4'ha, adc});
        run(16'h4003, r);
        chk(r, {4'h2, temp});
        settle(4);
        chk({15'h0000, busy1}, 16'h0000);
        run(16'h3001, r);
        chk(r, 16'h0000);
    endtask

    // reply buffer through the device: a result and a read queue up, then drain in order
    task automatic t_fifo;
        logic [15:0] r;
        run(16'h4002, r);
        chk(r, 16'h1008);
        run(16'h3002, r);
        chk(r, 16'h0000);
        run(16'h3001, r);
        chk(r, {4'ha, adc});
        run(16'h0000, r);
        chk(r, {4'h2, temp});
        run(16'h0000, r);
        chk(r, 16'h1008);
    endtask

    // short frame discarded, then reset pin clears the pins at once
    task automatic t_bb;
        bb(16'h1504, 16);
        bb(16'h1507, 16);
        bb(16'h2020, 16);
        settle(8);
        chk({8'h00, poe2}, 16'h00df);
        // acted on, these 8 bits would leave a gpio write of zero in the shifter
        bb(16'h0000, 8);
        settle(8);
        chk({15'h0000, pout2[5]}, 16'h0001);
        bb(16'h2000, 16);
        settle(8);
        chk({15'h0000, pout2[5]}, 16'h0000);
        @(posedge mclk);
        l2.rst_n <= 1'b0;
        #1;
        chk({pout2, poe2}, 16'h00ff);
        @(posedge mclk);
        l2.rst_n <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        l2.sclk           = 1'b0;
        l2.sync_n         = 1'b1;
        l2.serial_data_in = 1'b0;
        l2.rst_n          = 1'b0;
        repeat (20) @(posedge mclk);
        sys_rst  <= 1'b0;
        l2.rst_n <= 1'b1;
        t_regs();
        t_conv();
        t_fifo();
        t_bb();
        results();
    end
endmodule
